//--- src/mi_regs_pkg.sv
package mi_regs_pkg;

  // byte offsets on the register bus
  localparam logic [11:0] OFS_SECURE_ACCESS = 12'h008;
  localparam logic [11:0] OFS_IFACE_ID_0_3 = 12'h014;
  localparam logic [11:0] OFS_IFACE_ID_4_7 = 12'h018;
  localparam logic [11:0] OFS_IFACE_ID_8_11 = 12'h01C;
  localparam logic [11:0] OFS_IFACE_ID_12_15 = 12'h020;
  localparam logic [11:0] OFS_NODE_FEATURES = 12'h040;
  localparam logic [11:0] OFS_CHAN_DEBUG_MON = 12'h080;
  localparam logic [11:0] OFS_QOS_ACCEPT_CTRL = 12'h084;
  localparam logic [11:0] OFS_CMO_RESP_SELECT = 12'h088;
  localparam logic [11:0] OFS_SEC_IRQ_STATUS = 12'h0F0;
  localparam logic [11:0] OFS_SEC_IRQ_MASK = 12'h0F4;
  localparam logic [11:0] OFS_NS_IRQ_STATUS = 12'h0F8;
  localparam logic [11:0] OFS_NS_IRQ_MASK = 12'h0FC;

  // debug monitor field layout
  localparam int DBG_CAPTURE_BIT = 31;
  localparam int DBG_WR_OUT_LSB = 20;
  localparam int DBG_WR_OUT_MSB = 28;
  localparam int DBG_RD_OUT_LSB = 8;
  localparam int DBG_RD_OUT_MSB = 16;
  localparam int DBG_B_STALL_BIT = 4;
  localparam int DBG_W_STALL_BIT = 3;
  localparam int DBG_AW_STALL_BIT = 2;
  localparam int DBG_R_STALL_BIT = 1;
  localparam int DBG_AR_STALL_BIT = 0;
  localparam int OUTSTANDING_W = 9;

  // control field positions
  localparam int SACC_NS_ACCESS_BIT = 0;
  localparam int SACC_NS_DEBUG_BIT = 1;
  localparam int QOS_ARB_DIS_BIT = 0;
  localparam int QOS_STARVE_DIS_BIT = 1;
  localparam int CMO_UPGRADE_BIT = 0;
  localparam int IRQ_SPLIT_BIT = 0;
  localparam int IRQ_UNSUP_BIT = 1;
  localparam int IFACE_ID_W = 8;

  // reset values
  localparam logic [1:0] SECURE_ACCESS_RST = 2'h0;
  localparam logic [1:0] QOS_ACCEPT_RST = 2'h0;
  localparam logic CMO_UPGRADE_RST = 1'b0;
  localparam logic CAPTURE_EN_RST = 1'b1;
  localparam logic [1:0] IRQ_STATUS_RST = 2'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // handshake wires of the monitored master interface
  typedef struct packed {
    logic awvalid;
    logic awready;
    logic wvalid;
    logic wready;
    logic bvalid;
    logic bready;
    logic arvalid;
    logic arready;
    logic rvalid;
    logic rready;
    logic rlast;
  } axi_mon_t;

  // interrupt events from the datapath, one-cycle pulses
  typedef struct packed {
    logic unsup_acp;
    logic nonmod_split;
    logic non_secure;
  } irq_evt_t;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_RESP = 2'b10
  } apb_state_t;

endpackage

//--- src/outstanding_counter.sv
`timescale 1ns/1ps
`default_nettype none
module outstanding_counter #(
  parameter int WIDTH = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic issue,
  input wire logic retire,
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // saturate both ways so a stray retire cannot wrap to full scale
  always_comb begin
    count_d = count_q;
    if (issue && !retire && (count_q != {WIDTH{1'b1}})) begin
      count_d = count_q + WIDTH'(1);
    end else if (retire && !issue && (count_q != '0)) begin
      count_d = count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;

endmodule
`default_nettype wire

//--- src/master_interface_debug_irq_regs.sv
// Behaviour
// - id word 12-15 at 0x020; id words for interfaces 8-15 read zero
// - node-feature register reads all 32 bits as zero
// - monitor, qos, feature, cmo: secure, or non-secure once override set
// - debug monitor shows channel status; bit 31 is writable capture enable
// - bits 28:20 count writes from request handshake to response
// - bits 16:8 count reads from request handshake to response
// - bit 4 high while write response valid and not ready
// - bit 3 high while write data valid and not ready
// - bit 2 high while write address valid and not ready
// - bit 1 high while read data valid and not ready
// - bit 0 high while read address valid and not ready
// - qos bit 1 disables starvation avoidance, bit 0 disables arbitration
// - unsupported cmo answers slverr when upgrade bit set, else okay
// - secure status: bit 1 unsupported request, bit 0 non-modifiable split
// - status bit sets on its event and holds until software clears it
// - writing 1 clears a status bit, writing 0 leaves it
// - interrupt output high while any relevant status bit is set
// - secure mask: bit 1 unsupported request, bit 0 split; 1 masks
// - secure status and mask: secure access only, track secure events
// - non-secure status tracks non-secure events, no access restriction
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module master_interface_debug_irq_regs #(
  parameter logic [7:0] IFACE_ID = 8'h00
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mi_regs_pkg::axi_mon_t axi_mon,
  input wire mi_regs_pkg::irq_evt_t irq_evt,
  input wire logic cmo_unsupported,
  output logic cmo_resp_valid,
  output logic [1:0] cmo_resp,
  output logic qos_arb_disable,
  output logic qos_starve_disable,
  output logic irq_secure,
  output logic irq_nonsecure
);

  localparam int OW = mi_regs_pkg::OUTSTANDING_W;

  mi_regs_pkg::apb_state_t state_q;
  mi_regs_pkg::apb_state_t state_d;

  logic [1:0] secure_access_override_q;
  logic [1:0] qos_accept_q;
  logic cache_maint_err_upgrade_q;
  logic capture_en_q;
  logic [1:0] sec_stat_q;
  logic [1:0] sec_stat_d;
  logic [1:0] sec_mask_q;
  logic [1:0] ns_stat_q;
  logic [1:0] ns_stat_d;
  logic [1:0] ns_mask_q;
  logic [4:0] stall_q;
  logic [OW-1:0] wr_snap_q;
  logic [OW-1:0] rd_snap_q;
  logic [OW-1:0] wr_count;
  logic [OW-1:0] rd_count;
  logic [31:0] prdata_q;
  logic [31:0] rdata_d;
  logic pready_q;
  logic pslverr_q;
  logic cmo_resp_valid_q;
  logic [1:0] cmo_resp_q;
  logic irq_secure_q;
  logic irq_nonsecure_q;

  logic access;
  logic commit;
  logic wr_commit;
  logic non_secure;
  logic ns_allowed;
  logic hit_ok;
  logic mapped;
  logic allowed;
  logic [4:0] stall_live;
  logic [1:0] sec_set;
  logic [1:0] ns_set;
  logic [1:0] sec_clr;
  logic [1:0] ns_clr;

  // ---------------- bus handshake
  // one wait state: the answer is registered, so decode never sits
  // in the path from paddr to prdata
  assign access = psel && penable;
  assign commit = access && (state_q == mi_regs_pkg::APB_RESP);
  assign wr_commit = commit && pwrite && allowed;
  assign non_secure = pprot[1];

  always_comb begin
    state_d = state_q;
    case (state_q)
      mi_regs_pkg::APB_IDLE: begin
        if (access) begin
          state_d = mi_regs_pkg::APB_RESP;
        end
      end
      mi_regs_pkg::APB_RESP: begin
        state_d = mi_regs_pkg::APB_IDLE;
      end
      default: begin
        state_d = mi_regs_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= mi_regs_pkg::APB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------- address decode and security filter
  assign ns_allowed = |secure_access_override_q;

  always_comb begin
    mapped = 1'b1;
    hit_ok = 1'b1;
    case (paddr)
      mi_regs_pkg::OFS_IFACE_ID_0_3,
      mi_regs_pkg::OFS_IFACE_ID_4_7,
      mi_regs_pkg::OFS_IFACE_ID_8_11,
      mi_regs_pkg::OFS_IFACE_ID_12_15,
      mi_regs_pkg::OFS_NS_IRQ_STATUS,
      mi_regs_pkg::OFS_NS_IRQ_MASK: begin
        hit_ok = 1'b1;
      end
      mi_regs_pkg::OFS_NODE_FEATURES,
      mi_regs_pkg::OFS_CHAN_DEBUG_MON,
      mi_regs_pkg::OFS_QOS_ACCEPT_CTRL,
      mi_regs_pkg::OFS_CMO_RESP_SELECT: begin
        hit_ok = !non_secure || ns_allowed;
      end
      mi_regs_pkg::OFS_SECURE_ACCESS,
      mi_regs_pkg::OFS_SEC_IRQ_STATUS,
      mi_regs_pkg::OFS_SEC_IRQ_MASK: begin
        hit_ok = !non_secure;
      end
      default: begin
        mapped = 1'b0;
        hit_ok = 1'b0;
      end
    endcase
  end

  assign allowed = mapped && hit_ok;

  // ---------------- read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (allowed) begin
      case (paddr)
        mi_regs_pkg::OFS_SECURE_ACCESS: begin
          rdata_d[1:0] = secure_access_override_q;
        end
        mi_regs_pkg::OFS_IFACE_ID_0_3: begin
          rdata_d[mi_regs_pkg::IFACE_ID_W-1:0] = IFACE_ID;
        end
        mi_regs_pkg::OFS_CHAN_DEBUG_MON: begin
          rdata_d[mi_regs_pkg::DBG_CAPTURE_BIT] = capture_en_q;
          rdata_d[mi_regs_pkg::DBG_WR_OUT_MSB:mi_regs_pkg::DBG_WR_OUT_LSB] =
            wr_snap_q;
          rdata_d[mi_regs_pkg::DBG_RD_OUT_MSB:mi_regs_pkg::DBG_RD_OUT_LSB] =
            rd_snap_q;
          rdata_d[mi_regs_pkg::DBG_B_STALL_BIT:0] = stall_q;
        end
        mi_regs_pkg::OFS_QOS_ACCEPT_CTRL: begin
          rdata_d[1:0] = qos_accept_q;
        end
        mi_regs_pkg::OFS_CMO_RESP_SELECT: begin
          rdata_d[mi_regs_pkg::CMO_UPGRADE_BIT] = cache_maint_err_upgrade_q;
        end
        mi_regs_pkg::OFS_SEC_IRQ_STATUS: begin
          rdata_d[1:0] = sec_stat_q;
        end
        mi_regs_pkg::OFS_SEC_IRQ_MASK: begin
          rdata_d[1:0] = sec_mask_q;
        end
        mi_regs_pkg::OFS_NS_IRQ_STATUS: begin
          rdata_d[1:0] = ns_stat_q;
        end
        mi_regs_pkg::OFS_NS_IRQ_MASK: begin
          rdata_d[1:0] = ns_mask_q;
        end
        // id words 4-15 and node features stay zero
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access && (state_q == mi_regs_pkg::APB_IDLE);
      pslverr_q <= access && (state_q == mi_regs_pkg::APB_IDLE) && !allowed;
      if (access && (state_q == mi_regs_pkg::APB_IDLE) && !pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // ---------------- writable control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secure_access_override_q <= mi_regs_pkg::SECURE_ACCESS_RST;
    end else if (wr_commit && pstrb[0] &&
                 (paddr == mi_regs_pkg::OFS_SECURE_ACCESS)) begin
      secure_access_override_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qos_accept_q <= mi_regs_pkg::QOS_ACCEPT_RST;
    end else if (wr_commit && pstrb[0] &&
                 (paddr == mi_regs_pkg::OFS_QOS_ACCEPT_CTRL)) begin
      // bit 1 without bit 0 is left to software to avoid
      qos_accept_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cache_maint_err_upgrade_q <= mi_regs_pkg::CMO_UPGRADE_RST;
    end else if (wr_commit && pstrb[0] &&
                 (paddr == mi_regs_pkg::OFS_CMO_RESP_SELECT)) begin
      cache_maint_err_upgrade_q <= pwdata[mi_regs_pkg::CMO_UPGRADE_BIT];
    end
  end

  // only the capture bit is writable; counters and flags ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_en_q <= mi_regs_pkg::CAPTURE_EN_RST;
    end else if (wr_commit && pstrb[3] &&
                 (paddr == mi_regs_pkg::OFS_CHAN_DEBUG_MON)) begin
      capture_en_q <= pwdata[mi_regs_pkg::DBG_CAPTURE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_mask_q <= mi_regs_pkg::IRQ_MASK_RST;
    end else if (wr_commit && pstrb[0] &&
                 (paddr == mi_regs_pkg::OFS_SEC_IRQ_MASK)) begin
      sec_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ns_mask_q <= mi_regs_pkg::IRQ_MASK_RST;
    end else if (wr_commit && pstrb[0] &&
                 (paddr == mi_regs_pkg::OFS_NS_IRQ_MASK)) begin
      ns_mask_q <= pwdata[1:0];
    end
  end

  // ---------------- channel monitor
  // interconnect handshakes share pclk, so no synchroniser is needed
  assign stall_live[mi_regs_pkg::DBG_B_STALL_BIT] =
    axi_mon.bvalid && !axi_mon.bready;
  assign stall_live[mi_regs_pkg::DBG_W_STALL_BIT] =
    axi_mon.wvalid && !axi_mon.wready;
  assign stall_live[mi_regs_pkg::DBG_AW_STALL_BIT] =
    axi_mon.awvalid && !axi_mon.awready;
  assign stall_live[mi_regs_pkg::DBG_R_STALL_BIT] =
    axi_mon.rvalid && !axi_mon.rready;
  assign stall_live[mi_regs_pkg::DBG_AR_STALL_BIT] =
    axi_mon.arvalid && !axi_mon.arready;

  outstanding_counter #(
    .WIDTH(OW)
  ) u_wr_count (
    .pclk(pclk),
    .presetn(presetn),
    .issue(axi_mon.awvalid && axi_mon.awready),
    .retire(axi_mon.bvalid && axi_mon.bready),
    .count(wr_count)
  );

  outstanding_counter #(
    .WIDTH(OW)
  ) u_rd_count (
    .pclk(pclk),
    .presetn(presetn),
    .issue(axi_mon.arvalid && axi_mon.arready),
    .retire(axi_mon.rvalid && axi_mon.rready && axi_mon.rlast),
    .count(rd_count)
  );

  // clearing capture freezes the view for a consistent debug read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 5'h00;
      wr_snap_q <= '0;
      rd_snap_q <= '0;
    end else if (capture_en_q) begin
      stall_q <= stall_live;
      wr_snap_q <= wr_count;
      rd_snap_q <= rd_count;
    end
  end

  // ---------------- unsupported cache maintenance response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmo_resp_valid_q <= 1'b0;
      cmo_resp_q <= mi_regs_pkg::RESP_OKAY;
    end else begin
      cmo_resp_valid_q <= cmo_unsupported;
      if (cmo_unsupported) begin
        cmo_resp_q <= cache_maint_err_upgrade_q ?
          mi_regs_pkg::RESP_SLVERR : mi_regs_pkg::RESP_OKAY;
      end
    end
  end

  // ---------------- interrupt status
  assign sec_set = {irq_evt.unsup_acp, irq_evt.nonmod_split} &
                   {2{!irq_evt.non_secure}};
  assign ns_set = {irq_evt.unsup_acp, irq_evt.nonmod_split} &
                  {2{irq_evt.non_secure}};
  assign sec_clr = (wr_commit && pstrb[0] &&
                    (paddr == mi_regs_pkg::OFS_SEC_IRQ_STATUS)) ?
                   pwdata[1:0] : 2'h0;
  assign ns_clr = (wr_commit && pstrb[0] &&
                   (paddr == mi_regs_pkg::OFS_NS_IRQ_STATUS)) ?
                  pwdata[1:0] : 2'h0;

  // an event in the clearing cycle survives
  assign sec_stat_d = (sec_stat_q & ~sec_clr) | sec_set;
  assign ns_stat_d = (ns_stat_q & ~ns_clr) | ns_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_stat_q <= mi_regs_pkg::IRQ_STATUS_RST;
      ns_stat_q <= mi_regs_pkg::IRQ_STATUS_RST;
    end else begin
      sec_stat_q <= sec_stat_d;
      ns_stat_q <= ns_stat_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_secure_q <= 1'b0;
      irq_nonsecure_q <= 1'b0;
    end else begin
      irq_secure_q <= |(sec_stat_q & ~sec_mask_q);
      irq_nonsecure_q <= |(ns_stat_q & ~ns_mask_q);
    end
  end

  // ---------------- outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmo_resp_valid = cmo_resp_valid_q;
  assign cmo_resp = cmo_resp_q;
  assign qos_arb_disable = qos_accept_q[mi_regs_pkg::QOS_ARB_DIS_BIT];
  assign qos_starve_disable = qos_accept_q[mi_regs_pkg::QOS_STARVE_DIS_BIT];
  assign irq_secure = irq_secure_q;
  assign irq_nonsecure = irq_nonsecure_q;

endmodule
`default_nettype wire

//--- test/mi_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mi_regs_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmo_unsupported,
  input wire logic cmo_resp_valid,
  input wire logic [1:0] cmo_resp,
  input wire logic qos_arb_disable,
  input wire logic qos_starve_disable,
  input wire logic irq_secure
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic done;
  logic wr_done;
  logic [1:0] qos_wdata;
  assign done = psel && penable && pready;
  assign wr_done = done && pwrite;
  assign qos_wdata = pwdata[1:0];

  sec_deny_a: assert property (done && pprot[1] &&
    (paddr == mi_regs_pkg::OFS_SEC_IRQ_STATUS ||
     paddr == mi_regs_pkg::OFS_SEC_IRQ_MASK) |-> pslverr)
    else $error("secure irq register open to non-secure access");
  ns_open_a: assert property (done &&
    paddr == mi_regs_pkg::OFS_NS_IRQ_STATUS |-> !pslverr)
    else $error("non-secure status refused");
  id_zero_a: assert property (done && !pwrite &&
    (paddr == mi_regs_pkg::OFS_IFACE_ID_8_11 ||
     paddr == mi_regs_pkg::OFS_IFACE_ID_12_15) |-> prdata == 32'h0)
    else $error("reserved id word not zero");
  feat_zero_a: assert property (done && !pwrite &&
    paddr == mi_regs_pkg::OFS_NODE_FEATURES |-> prdata == 32'h0)
    else $error("node feature word not zero");
  mon_rsvd_a: assert property (done && !pwrite &&
    paddr == mi_regs_pkg::OFS_CHAN_DEBUG_MON |-> prdata[30:29] == 2'h0
    && prdata[19:17] == 3'h0 && prdata[7:5] == 3'h0)
    else $error("monitor reserved bits set");
  qos_mirror_a: assert property (done && pwrite && !pslverr &&
    paddr == mi_regs_pkg::OFS_QOS_ACCEPT_CTRL |=>
    {qos_starve_disable, qos_arb_disable} == $past(qos_wdata))
    else $error("qos outputs do not follow write");
  cmo_answer_a: assert property (cmo_unsupported |=> cmo_resp_valid)
    else $error("cmo request not answered");
  cmo_hold_a: assert property (!cmo_unsupported |=>
    $stable(cmo_resp))
    else $error("cmo response changed without a request");
  irq_clear_a: assert property ($fell(irq_secure) |->
    $past(wr_done, 1) || $past(wr_done, 2))
    else $error("secure irq dropped without a write");
  pready_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("access not completed after one wait state");
endmodule
bind master_interface_debug_irq_regs mi_regs_asserts chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pprot(pprot),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .cmo_unsupported(cmo_unsupported),
  .cmo_resp_valid(cmo_resp_valid),
  .cmo_resp(cmo_resp),
  .qos_arb_disable(qos_arb_disable),
  .qos_starve_disable(qos_starve_disable),
  .irq_secure(irq_secure)
);
`default_nettype wire

//--- test/axi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module axi_slave_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic awvalid,
  input wire logic arvalid,
  input wire logic bready,
  input wire logic rready,
  output logic ready,
  output logic bvalid,
  output logic rvalid,
  output logic rlast
);
  logic [7:0] wpend_q;
  logic [7:0] rpend_q;
  // one ready for aw, w and ar keeps stall windows aligned
  assign ready = !stall;
  assign bvalid = wpend_q != 8'h00;
  assign rvalid = rpend_q != 8'h00;
  // single-beat reads, so every beat is the last
  assign rlast = rvalid;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wpend_q <= 8'h00;
      rpend_q <= 8'h00;
    end else begin
      wpend_q <= wpend_q + 8'(awvalid && ready) - 8'(bvalid && bready);
      rpend_q <= rpend_q + 8'(arvalid && ready) - 8'(rvalid && rready);
    end
  end
endmodule
`default_nettype wire

//--- test/tb_master_interface_debug_irq_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  n_compared++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
  end
module tb_master_interface_debug_irq_regs;
  localparam logic [11:0] MON = mi_regs_pkg::OFS_CHAN_DEBUG_MON;
  localparam logic [11:0] QOS = mi_regs_pkg::OFS_QOS_ACCEPT_CTRL;
  localparam logic [11:0] CMO = mi_regs_pkg::OFS_CMO_RESP_SELECT;
  localparam logic [11:0] SAC = mi_regs_pkg::OFS_SECURE_ACCESS;
  localparam logic [11:0] SST = mi_regs_pkg::OFS_SEC_IRQ_STATUS;
  localparam logic [11:0] SMK = mi_regs_pkg::OFS_SEC_IRQ_MASK;
  localparam logic [11:0] NST = mi_regs_pkg::OFS_NS_IRQ_STATUS;
  localparam logic [11:0] RST_A [8] = '{12'h014, 12'h018, 12'h01C,
    12'h020, 12'h040, MON, QOS, CMO};
  localparam logic [31:0] QV [3] = '{32'h0, 32'h1, 32'h3};
  logic pclk, presetn, psel, penable, pwrite, cmo_unsupported;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] pprot;
  logic pready, pslverr, cmo_resp_valid, qos_arb, qos_starve, irq_s, irq_ns;
  logic [1:0] cmo_resp;
  mi_regs_pkg::irq_evt_t irq_evt;
  mi_regs_pkg::axi_mon_t mon;
  logic stall, aw_v, ar_v, b_r, r_r, ready, b_v, r_v, r_last;
  int errors, n_compared, cycles, k, j;
  logic [33:0] exp_q[$];
  logic [33:0] e;

  assign mon = {aw_v, ready, aw_v, ready, b_v, b_r, ar_v, ready, r_v, r_r,
    r_last};
  always #5 pclk = ~pclk;

  master_interface_debug_irq_regs dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .axi_mon(mon), .irq_evt(irq_evt),
    .cmo_unsupported(cmo_unsupported), .cmo_resp_valid(cmo_resp_valid),
    .cmo_resp(cmo_resp), .qos_arb_disable(qos_arb),
    .qos_starve_disable(qos_starve), .irq_secure(irq_s),
    .irq_nonsecure(irq_ns));
  axi_slave_model slv (.pclk(pclk), .presetn(presetn), .stall(stall),
    .awvalid(aw_v), .arvalid(ar_v), .bready(b_r), .rready(r_r),
    .ready(ready), .bvalid(b_v), .rvalid(r_v), .rlast(r_last));

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d, input logic ns, input logic [31:0] ed,
      input logic ee);
    exp_q.push_back({!w, ee, ed});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic ns,
      input logic [31:0] ed, input logic ee);
    apb(a, 1'b0, 32'h0, ns, ed, ee);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic ns, input logic ee);
    apb(a, 1'b1, d, ns, 32'h0, ee);
  endtask

  task automatic evt(input logic [2:0] v);
    irq_evt <= v;
    @(posedge pclk);
    irq_evt <= 3'h0;
    tick(3);
  endtask

  always @(posedge pclk) begin
    if (pready === 1'b1 || cmo_resp_valid === 1'b1) begin
      e = exp_q.pop_front();
      if (cmo_resp_valid === 1'b1) begin
        `CHK("cmo_resp", e[1:0], cmo_resp)
      end else begin
        `CHK("pslverr", e[32], pslverr)
        if (e[33]) begin
          `CHK("prdata", e[31:0], prdata)
        end
      end
    end
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, cmo_unsupported} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pprot = 3'h0;
    irq_evt = 3'h0;
    {stall, aw_v, ar_v, b_r, r_r} = 5'h00;
    k = $urandom(95);
    tick(5);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (RST_A[i]) begin
      rd(RST_A[i], 0, (RST_A[i] == MON) ? 32'h80000000 : 32'h0, 0);
    end
    wr(12'h040, $urandom, 0, 0);
    rd(12'h040, 0, 32'h0, 0);
    $display("reset values done");
    rd(MON, 1, 32'h0, 1);
    rd(SST, 1, 32'h0, 1);
    rd(12'h0AC, 0, 32'h0, 1);
    wr(SAC, 32'h3, 1, 1);
    for (int b = 0; b < 2; b++) begin
      wr(SAC, 32'h1 << b, 0, 0);
      rd(MON, 1, 32'h80000000, 0);
      rd(SMK, 1, 32'h0, 1);
    end
    wr(SAC, 32'h0, 0, 0);
    $display("security done");
    // bit1 set with bit0 clear is never written
    foreach (QV[i]) begin
      wr(QOS, QV[i], 0, 0);
      rd(QOS, 0, QV[i], 0);
      `CHK("qos", QV[i][1:0], {qos_starve, qos_arb})
    end
    $display("qos done");
    for (int v = 0; v < 2; v++) begin
      wr(CMO, v, 0, 0);
      exp_q.push_back({32'h0, v ? mi_regs_pkg::RESP_SLVERR :
        mi_regs_pkg::RESP_OKAY});
      cmo_unsupported <= 1'b1;
      @(posedge pclk);
      cmo_unsupported <= 1'b0;
      tick(2);
    end
    $display("cmo done");
    evt(3'b100);
    rd(SST, 0, 32'h2, 0);
    `CHK("irq_secure", 1'b1, irq_s)
    wr(SST, 32'h1, 0, 0);
    rd(SST, 0, 32'h2, 0);
    wr(SST, 32'h2, 0, 0);
    rd(SST, 0, 32'h0, 0);
    `CHK("irq_secure", 1'b0, irq_s)
    wr(SMK, 32'h1, 0, 0);
    evt(3'b010);
    rd(SST, 0, 32'h1, 0);
    `CHK("irq_secure", 1'b0, irq_s)
    wr(SST, 32'h1, 0, 0);
    wr(SMK, 32'h0, 0, 0);
    evt(3'b011);
    rd(NST, 1, 32'h1, 0);
    rd(SST, 0, 32'h0, 0);
    `CHK("irq_nonsecure", 1'b1, irq_ns)
    wr(NST, 32'h1, 1, 0);
    tick(1);
    `CHK("irq_nonsecure", 1'b0, irq_ns)
    $display("interrupts done");
    stall <= 1'b1;
    aw_v <= 1'b1;
    ar_v <= 1'b1;
    tick(3);
    rd(MON, 0, 32'h8000000D, 0);
    k = 1 + $urandom % 20;
    j = 1 + $urandom % 20;
    stall <= 1'b0;
    for (int i = 1; i <= 20; i++) begin
      @(posedge pclk);
      aw_v <= i < k;
      ar_v <= i < j;
    end
    tick(3);
    rd(MON, 0, 32'h80000012 | k << 20 | j << 8, 0);
    b_r <= 1'b1;
    r_r <= 1'b1;
    tick(30);
    rd(MON, 0, 32'h80000000, 0);
    wr(MON, 32'h7FFFFFFF, 0, 0);
    stall <= 1'b1;
    aw_v <= 1'b1;
    tick(3);
    rd(MON, 0, 32'h0, 0);
    $display("monitor done");
    summarize();
  end
endmodule
`default_nettype wire
